// File: hdl/iip_port.v
// isolated input port card: i/o slave, base decode and two edge interrupts
// Functional notes
// - four bytes hold 32 inputs, lowest first
// - four consecutive ports, low address bits select
// - base range 200h to 3FCh
// - base defaults to 300h
// - switch positions 1-8 compare A9-A2
// - interrupts from channels 0 and 16
// - irq routed to one of eight levels
// - separate edge jumper per source
// - write offset 0/2 clears matching flag
// - fire on jumper-selected rising/falling edge
// - removed level jumper drives no irq
`timescale 1ns/1ps
`include "iip_consts.vh"
module iip_port (
    input wire clk,
    input wire arst_n,
    input wire [9:0] bus_addr,
    input wire bus_aen,
    input wire bus_ior_n,
    input wire bus_iow_n,
    output reg [7:0] bus_data_out,
    output reg bus_data_oe,
    input wire [31:0] isolated_input,
    input wire [7:0] base_address_switch,
    input wire ch0_level_fitted,
    input wire [2:0] ch0_irq_level_jumper,
    input wire ch16_level_fitted,
    input wire [2:0] ch16_irq_level_jumper,
    input wire ch0_edge_jumper,
    input wire ch16_edge_jumper,
    output reg [7:0] irq_line,
    output reg ch0_flag_reg,
    output reg ch16_flag_reg
);
    // everything from the bus and pins is asynchronous to clk
    reg [9:0] addr_s1_reg;
    reg [9:0] addr_s2_reg;
    reg aen_s1_reg;
    reg aen_s2_reg;
    reg ior_s1_reg;
    reg ior_s2_reg;
    reg iow_s1_reg;
    reg iow_s2_reg;
    reg iow_prev_reg;
    reg [31:0] in_s1_reg;
    reg [31:0] in_s2_reg;
    reg [7:0] sw_s1_reg;
    reg [7:0] sw_s2_reg;
    reg [7:0] base_reg;
    reg ch0_prev_reg, ch16_prev_reg;
    reg fit0_s1_reg;
    reg fit0_s2_reg;
    reg fit16_s1_reg;
    reg fit16_s2_reg;
    reg [2:0] lvl0_s1_reg;
    reg [2:0] lvl0_s2_reg;
    reg [2:0] lvl16_s1_reg;
    reg [2:0] lvl16_s2_reg;
    reg edg0_s1_reg;
    reg edg0_s2_reg;
    reg edg16_s1_reg;
    reg edg16_s2_reg;
    reg [1:0] settle_reg;
    reg [1:0] settle_next;
    reg [7:0] data_next;
    reg [7:0] irq_next;
    wire selected;
    wire rd_act;
    wire wr_pulse;
    wire ch0_edge;
    wire ch16_edge;
    wire edges_live;
    wire wr_low;
    wire wr_third;
    wire [7:0] irq_from0;
    wire [7:0] irq_from16;

    // level code 0..7 maps to irq 2,3,5,7,10,11,12,15 on irq_line bits
    function [7:0] level_onehot;
        input fitted;
        input [2:0] code;
        begin
            level_onehot = fitted ? (8'h01 << code) : 8'h00;
        end
    endfunction

    function edge_hit;
        input now;
        input prev;
        input rising;
        begin
            edge_hit = rising ? (now & ~prev) : (~now & prev);
        end
    endfunction

    function offset_hit;
        input [1:0] addr_low;
        input [1:0] ofs;
        begin
            offset_hit = (addr_low == ofs);
        end
    endfunction

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_s1_reg <= 10'h000;
            addr_s2_reg <= 10'h000;
            aen_s1_reg <= 1'b1;
            aen_s2_reg <= 1'b1;
            ior_s1_reg <= 1'b1;
            ior_s2_reg <= 1'b1;
            iow_s1_reg <= 1'b1;
            iow_s2_reg <= 1'b1;
            iow_prev_reg <= 1'b1;
        end else begin
            addr_s1_reg <= bus_addr;
            addr_s2_reg <= addr_s1_reg;
            aen_s1_reg <= bus_aen;
            aen_s2_reg <= aen_s1_reg;
            ior_s1_reg <= bus_ior_n;
            ior_s2_reg <= ior_s1_reg;
            iow_s1_reg <= bus_iow_n;
            iow_s2_reg <= iow_s1_reg;
            iow_prev_reg <= iow_s2_reg;
        end
    end

    // channel levels get their own pair of flops
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            in_s1_reg <= 32'h0000_0000;
            in_s2_reg <= 32'h0000_0000;
        end else begin
            in_s1_reg <= isolated_input;
            in_s2_reg <= in_s1_reg;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sw_s1_reg <= `IIP_BASE_DEFAULT;
            sw_s2_reg <= `IIP_BASE_DEFAULT;
        end else begin
            sw_s1_reg <= base_address_switch;
            sw_s2_reg <= sw_s1_reg;
        end
    end

    // jumpers are pins too; a move must not glitch the edge or level decode
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fit0_s1_reg <= 1'b0;
            fit0_s2_reg <= 1'b0;
            fit16_s1_reg <= 1'b0;
            fit16_s2_reg <= 1'b0;
            lvl0_s1_reg <= 3'h0;
            lvl0_s2_reg <= 3'h0;
            lvl16_s1_reg <= 3'h0;
            lvl16_s2_reg <= 3'h0;
            edg0_s1_reg <= 1'b1;
            edg0_s2_reg <= 1'b1;
            edg16_s1_reg <= 1'b1;
            edg16_s2_reg <= 1'b1;
        end else begin
            fit0_s1_reg <= ch0_level_fitted;
            fit0_s2_reg <= fit0_s1_reg;
            fit16_s1_reg <= ch16_level_fitted;
            fit16_s2_reg <= fit16_s1_reg;
            lvl0_s1_reg <= ch0_irq_level_jumper;
            lvl0_s2_reg <= lvl0_s1_reg;
            lvl16_s1_reg <= ch16_irq_level_jumper;
            lvl16_s2_reg <= lvl16_s1_reg;
            edg0_s1_reg <= ch0_edge_jumper;
            edg0_s2_reg <= edg0_s1_reg;
            edg16_s1_reg <= ch16_edge_jumper;
            edg16_s2_reg <= edg16_s1_reg;
        end
    end

    // edge detect waits until the sync chain holds real pin levels
    always @* begin
        settle_next = settle_reg;
        if (settle_reg != `IIP_SETTLE_DONE) begin
            settle_next = settle_reg + `IIP_SETTLE_STEP;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_reg <= `IIP_SETTLE_ZERO;
        end else begin
            settle_reg <= settle_next;
        end
    end

    // a pin already high at release would otherwise look like an edge
    assign edges_live = (settle_reg == `IIP_SETTLE_DONE);

    // base starts at the factory value until the switch has been sampled
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            base_reg <= `IIP_BASE_DEFAULT;
        end else begin
            base_reg <= sw_s2_reg;
        end
    end

    // a9 must be set, which keeps the card inside 200h..3FFh
    assign selected = !aen_s2_reg && base_reg[`IIP_BASE_TOP_BIT]
        && (addr_s2_reg[9:2] == base_reg);
    assign rd_act = selected && !ior_s2_reg;
    assign wr_pulse = selected && !iow_s2_reg && iow_prev_reg;
    // clear strobes; offsets 1 and 3 decode to nothing
    assign wr_low = wr_pulse && offset_hit(addr_s2_reg[1:0], `IIP_OFS_LOW);
    assign wr_third = wr_pulse && offset_hit(addr_s2_reg[1:0], `IIP_OFS_THIRD);

    // a read held low keeps refreshing the byte from live inputs

    always @* begin
        case (addr_s2_reg[1:0])
            `IIP_OFS_LOW: data_next = in_s2_reg[7:0];
            `IIP_OFS_SECOND: data_next = in_s2_reg[15:8];
            `IIP_OFS_THIRD: data_next = in_s2_reg[23:16];
            `IIP_OFS_HIGH: data_next = in_s2_reg[31:24];
            default: data_next = 8'h00;
        endcase
    end

    // reads only drive the bus, no state changes
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_data_out <= 8'h00;
        end else begin
            bus_data_out <= rd_act ? data_next : 8'h00;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_data_oe <= 1'b0;
        end else begin
            bus_data_oe <= rd_act;
        end
    end

    assign ch0_edge = edges_live
        && edge_hit(in_s2_reg[`IIP_CH_ZERO], ch0_prev_reg, edg0_s2_reg);
    assign ch16_edge = edges_live
        && edge_hit(in_s2_reg[`IIP_CH_SIXTEEN], ch16_prev_reg, edg16_s2_reg);

    // set beats a clear landing in the same cycle so no edge is lost
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ch0_prev_reg <= 1'b0;
            ch0_flag_reg <= 1'b0;
        end else begin
            ch0_prev_reg <= in_s2_reg[`IIP_CH_ZERO];
            if (ch0_edge) begin
                ch0_flag_reg <= 1'b1;
            end else if (wr_low) begin
                ch0_flag_reg <= 1'b0;
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ch16_prev_reg <= 1'b0;
            ch16_flag_reg <= 1'b0;
        end else begin
            ch16_prev_reg <= in_s2_reg[`IIP_CH_SIXTEEN];
            if (ch16_edge) begin
                ch16_flag_reg <= 1'b1;
            end else if (wr_third) begin
                ch16_flag_reg <= 1'b0;
            end
        end
    end

    // a pulled level jumper routes nowhere, the flag itself still sets
    assign irq_from0 = level_onehot(fit0_s2_reg, lvl0_s2_reg);
    assign irq_from16 = level_onehot(fit16_s2_reg, lvl16_s2_reg);

    always @* begin
        irq_next = 8'h00;
        if (ch0_flag_reg) begin
            irq_next = irq_next | irq_from0;
        end
        if (ch16_flag_reg) begin
            irq_next = irq_next | irq_from16;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_line <= 8'h00;
        end else begin
            irq_line <= irq_next;
        end
    end
endmodule // iip_port

// File: inc/iip_consts.vh
// constants for the isolated input port card
`ifndef IIP_CONSTS_VH
`define IIP_CONSTS_VH
`define IIP_OFS_LOW 2'h0
`define IIP_OFS_SECOND 2'h1
`define IIP_OFS_THIRD 2'h2
`define IIP_OFS_HIGH 2'h3
`define IIP_BASE_DEFAULT 8'hC0
`define IIP_BASE_TOP_BIT 7
`define IIP_CH_ZERO 0
`define IIP_CH_SIXTEEN 16
`define IIP_LEVELS 8
`define IIP_BYTE 8
`define IIP_SETTLE_ZERO 2'h0
`define IIP_SETTLE_STEP 2'h1
`define IIP_SETTLE_DONE 2'h3
`endif

// File: tb/iip_host.sv
// host model issuing i/o read and write cycles
`timescale 1ns/1ps
module iip_host (
    input wire clk,
    input wire [7:0] bus_data_out,
    input wire bus_data_oe,
    output reg [9:0] bus_addr = 10'h000,
    output reg bus_aen = 1'b0,
    output reg bus_ior_n = 1'b1,
    output reg bus_iow_n = 1'b1
);
    // only i/o cycles; a refused read gives up after six clocks
    task automatic cyc(input [9:0] a, input rd, input dma, output [7:0] d, output ok);
        integer n;
        begin
            @(posedge clk) #2;
            {bus_addr, bus_aen} = {a, dma};
            @(posedge clk) #2;
            {bus_ior_n, bus_iow_n} = {!rd, rd};
            for (n = 0; n < 6 && !(rd && bus_data_oe); n++) @(posedge clk) #2;
            {ok, d} = {bus_data_oe, bus_data_out};
            {bus_ior_n, bus_iow_n} = 2'h3;
            repeat (4) @(posedge clk);
            #2 {bus_addr, bus_aen} = {~a, 1'b0};
        end
    endtask
endmodule // iip_host

// File: tb/iip_port_assertions.sv
// port checks for the input port card
`timescale 1ns/1ps
module iip_port_assertions (
    input wire clk,
    input wire arst_n,
    input wire bus_aen,
    input wire bus_ior_n,
    input wire bus_iow_n,
    input wire bus_data_oe,
    input wire ch0_level_fitted,
    input wire ch16_level_fitted,
    input wire [2:0] ch0_irq_level_jumper,
    input wire [7:0] irq_line,
    input wire ch0_flag_reg,
    input wire ch16_flag_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_on0; ch0_flag_reg && ch0_level_fitted; endsequence
    sequence s_mute; !ch0_level_fitted && !ch16_level_fitted; endsequence
    oe_rise_a: assert property ($rose(bus_data_oe) |-> !$past(bus_ior_n, 2))
        else $error("oe without read");
    oe_drop_a: assert property ($rose(bus_ior_n) ##0 bus_data_oe |-> ##[1:4] !bus_data_oe)
        else $error("oe stuck");
    dma_quiet_a: assert property (bus_aen [*4] |-> !bus_data_oe)
        else $error("answer in dma");
    clear_cause_a: assert property ($fell(ch0_flag_reg) || $fell(ch16_flag_reg)
        |-> !$past(bus_iow_n, 2)) else $error("flag lost");
    flag_hold_a: assert property (ch0_flag_reg && bus_iow_n && $past(bus_iow_n, 2)
        |=> ch0_flag_reg) else $error("flag dropped");
    irq_cause_a: assert property (|irq_line |-> $past(ch0_flag_reg || ch16_flag_reg))
        else $error("irq without flag");
    irq_route_a: assert property (s_on0 ##1 s_on0 |-> irq_line[ch0_irq_level_jumper])
        else $error("irq level wrong");
    irq_mute_a: assert property (s_mute [*2] |-> irq_line == 8'h00)
        else $error("irq while unfitted");
endmodule // iip_port_assertions
bind iip_port iip_port_assertions u_chk (.*);

// File: tb/iip_port_tb_top.sv
// self-checking bench for the input port card
`timescale 1ns/1ps
module iip_port_tb_top;
    reg clk = 1'b0, arst_n = 1'b0, fit = 1'b1, e0 = 1'b1, e16 = 1'b1, ok;
    reg [31:0] din = 32'h0000_0000, m;
    reg [7:0] sw = 8'hC0, d;
    reg [2:0] lv0 = 3'h0, lv16 = 3'h0;
    wire [9:0] bus_addr;
    wire bus_aen, bus_ior_n, bus_iow_n, bus_data_oe, ch0_flag_reg, ch16_flag_reg;
    wire [7:0] bus_data_out, irq_line;
    wire [8:0] flags = {7'h00, ch16_flag_reg, ch0_flag_reg};
    integer error_cnt = 0, check_count = 0, cyc = 0, i, k;
    iip_port uut (.*, .isolated_input(din), .base_address_switch(sw), .ch0_level_fitted(fit),
        .ch16_level_fitted(fit), .ch0_irq_level_jumper(lv0), .ch16_irq_level_jumper(lv16),
        .ch0_edge_jumper(e0), .ch16_edge_jumper(e16));
    iip_host uh (.*);
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        if (++cyc == 5000) begin
            error_cnt++;
            close_out;
        end
    end
    task chk(input [8:0] got, input [8:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task acc(input [1:0] o, input rd);
        uh.cyc({sw, o}, rd, 1'b0, d, ok);
    endtask
    task step(input integer n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    function [8:0] rd_exp(input [31:0] v, input [1:0] o);
        rd_exp = {1'b1, v[8 * o +: 8]};
    endfunction
    task close_out;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        i = $urandom(99830);
        step(4);
        arst_n = 1'b1;
        // hit, wrong address bit, dma cycle, base below 200h
        for (i = 0; i < 48; i++) begin
            if (i % 4 == 0) sw = i == 0 ? 8'hC0 : i == 4 ? 8'h80 : {1'b1, 7'($urandom)};
            if (i == 8) sw = 8'hFC;
            if (i % 4 == 3) sw[7] = 1'b0;
            din = $urandom;
            step(3);
            uh.cyc({sw ^ (i % 4 == 1 ? 8'h01 << i / 4 % 8 : 8'h00), 2'(i / 4)}, 1'b1,
                i % 4 == 2, d, ok);
            chk({ok, d}, i % 4 == 0 ? rd_exp(din, 2'(i / 4)) : 9'h000);
        end
        $display("test decode done");
        sw = 8'hC0;
        for (k = 0; k < 8; k++) begin
            m = k[0] ? 32'h0001_0000 : 32'h0000_0001;
            din = k[1] ? din & ~m : din | m;
            step(4);
            acc(2'h0, 1'b0);
            acc(2'h2, 1'b0);
            e0 = k[1] ^ k[0];
            e16 = ~e0;
            fit = !k[2];
            {lv0, lv16} = 6'($urandom);
            din = din ^ m;
            step(5);
            chk(flags, 9'h001 << k[0]);
            chk(irq_line, k[2] ? 9'h000 : 9'h001 << (k[0] ? lv16 : lv0));
            repeat (2) begin
                din = din ^ m;
                step(4);
            end
            acc(2'h1, 1'b0);
            acc(2'h3, 1'b0);
            acc({k[0], 1'b0}, 1'b1);
            chk(flags, 9'h001 << k[0]);
            acc({k[0], 1'b0}, 1'b0);
            chk(flags | irq_line, 9'h000);
            din = din ^ m;
            step(5);
            chk(flags, 9'h000);
        end
        $display("test interrupts done");
        close_out;
    end
endmodule // iip_port_tb_top
